// ### rtl/dclb_pkg.sv
/*
  Package for the dual-clock line buffer: geometry, pointer reset values
  and synchroniser depth.
  Assumes nothing of its surroundings; every file refers to it by scope.
*/
package dclb_pkg;
  // ***************************************************
  // Geometry
  // ***************************************************
  localparam int unsigned DEPTH      = 5048;
  localparam int unsigned WIDTH      = 8;
  localparam int unsigned ADDR_W     = 13;
  localparam logic [12:0] LAST_ADDR  = 13'h13B7;
  localparam logic [12:0] PTR_RESET  = 13'h0000;
  // ***************************************************
  // Pin sampling
  // ***************************************************
  localparam int unsigned SYNC_STAGES = 3;
endpackage

// ### rtl/dclb_store.sv
/*
  Word store of the line buffer: one write port, one combinational read port.
  Assumes the caller keeps both addresses below the depth.
*/
`timescale 1ns/1ps
module dclb_store #(
  parameter int unsigned DEPTH  = dclb_pkg::DEPTH,
  parameter int unsigned WIDTH  = dclb_pkg::WIDTH,
  parameter int unsigned ADDR_W = dclb_pkg::ADDR_W
) (
  // Clock
  input  wire logic              mclk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WIDTH-1:0]  rd_data
);
  // ***************************************************
  // Storage
  // ***************************************************
  // No reset on purpose: contents are held as long as power is applied.
  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_ff[rd_addr];
endmodule

// ### rtl/dclb_top.sv
/*
  Dual-clock line buffer: FIFO-ordered line store with independent put and
  fetch sides, each driven by its own slow pin clock and gated per cycle.
  Assumes every pin level, clock or control, stands at least four mclk
  cycles, so each is accepted through the three-stage samplers before it
  moves again; a write and a read of one cell never share an mclk edge.
*/
// Contract
// - 5048 by 8 words, FIFO pointer order
// - Input byte captured at cycle-ending edge
// - Late capture allows shared-clock line delay
// - Read byte presented after cycle-starting edge
// - Controls sampled on their own side's edge
// - Gate low: write and advance pointer
// - Gate high: skip write, hold pointer
// - Gate low: read byte, advance pointer
// - Gate high: skip read, float output
// - Write pointer wraps from 5047 to 0
// - Put clear zeroes write pointer
// - Fetch clear zeroes read pointer
// - Clears act regardless of gates
// - Put and fetch sides run independently
// - Stored bytes kept without refresh
`timescale 1ns/1ps
module dclb_top #(
  parameter int unsigned DEPTH  = dclb_pkg::DEPTH,
  parameter int unsigned WIDTH  = dclb_pkg::WIDTH,
  parameter int unsigned ADDR_W = dclb_pkg::ADDR_W
) (
  // System
  input  wire logic             mclk,
  input  wire logic             rst,
  // Put side pins
  input  wire logic             put_side_clock,
  input  wire logic             put_gate_n,
  input  wire logic             put_pointer_clear_n,
  input  wire logic [WIDTH-1:0] put_data,
  // Fetch side pins
  input  wire logic             fetch_side_clock,
  input  wire logic             fetch_gate_n,
  input  wire logic             fetch_pointer_clear_n,
  output logic      [WIDTH-1:0] fetch_data,
  output logic                  fetch_data_oe
);
  localparam int unsigned PW = WIDTH + 3;
  localparam int unsigned FW = 3;
  localparam int unsigned NS = dclb_pkg::SYNC_STAGES;
  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(DEPTH - 1);
  localparam logic [ADDR_W-1:0] ONE  = ADDR_W'(1);

  // ***************************************************
  // Pin samplers
  // ***************************************************
  // Three stages per pin; the first stage feeds only the second.
  logic [PW-1:0] put_sync_ff   [NS];
  logic [FW-1:0] fetch_sync_ff [NS];
  wire  [PW-1:0] put_pins   = {put_side_clock, put_gate_n, put_pointer_clear_n, put_data};
  wire  [FW-1:0] fetch_pins = {fetch_side_clock, fetch_gate_n, fetch_pointer_clear_n};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      if (g == 0) begin : g_first
        always_ff @(posedge mclk) begin
          put_sync_ff[g]   <= put_pins;
          fetch_sync_ff[g] <= fetch_pins;
        end
      end else begin : g_next
        always_ff @(posedge mclk) begin
          put_sync_ff[g]   <= put_sync_ff[g-1];
          fetch_sync_ff[g] <= fetch_sync_ff[g-1];
        end
      end
    end
  endgenerate

  // ***************************************************
  // Pin filters
  // ***************************************************
  // A bit is taken once the second and third stages agree; until then the
  // last accepted level stands, so a level caught in transition never counts.
  logic [PW-1:0] put_seen_ff;
  logic [FW-1:0] fetch_seen_ff;
  wire  [PW-1:0] put_agree      = ~(put_sync_ff[1] ^ put_sync_ff[2]);
  wire  [FW-1:0] fetch_agree    = ~(fetch_sync_ff[1] ^ fetch_sync_ff[2]);
  wire  [PW-1:0] nxt_put_seen   = (put_agree & put_sync_ff[2]) | (~put_agree & put_seen_ff);
  wire  [FW-1:0] nxt_fetch_seen = (fetch_agree & fetch_sync_ff[2])
                                | (~fetch_agree & fetch_seen_ff);

  // No reset: the filters follow the pins, so the accepted level after reset
  // is the pin's idle level and no false edge follows reset.
  always_ff @(posedge mclk) begin
    put_seen_ff   <= nxt_put_seen;
    fetch_seen_ff <= nxt_fetch_seen;
  end

  // Own-side edge sampling
  // Controls and data are the accepted levels at the accepted clock rise.
  wire             put_edge    = nxt_put_seen[PW-1] & ~put_seen_ff[PW-1];
  wire             put_go      = ~nxt_put_seen[PW-2];
  wire             put_clear   = ~nxt_put_seen[PW-3];
  wire [WIDTH-1:0] put_byte    = nxt_put_seen[WIDTH-1:0];
  wire             fetch_edge  = nxt_fetch_seen[FW-1] & ~fetch_seen_ff[FW-1];
  wire             fetch_go    = ~nxt_fetch_seen[FW-2];
  wire             fetch_clear = ~nxt_fetch_seen[FW-3];

  // ***************************************************
  // Put side
  // ***************************************************
  logic [ADDR_W-1:0] put_ptr_ff;
  logic [ADDR_W-1:0] put_cell_ff;
  logic              put_open_ff;

  wire [ADDR_W-1:0] put_base     = put_clear ? dclb_pkg::PTR_RESET : put_ptr_ff;
  wire [ADDR_W-1:0] put_step     = (put_base == LAST) ? dclb_pkg::PTR_RESET : put_base + ONE;
  wire [ADDR_W-1:0] nxt_put_ptr  = put_go ? put_step : put_base;
  // Pending byte commits on the same mclk edge that opens the new cycle
  wire              store_wr_en  = put_edge & put_open_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      put_ptr_ff <= dclb_pkg::PTR_RESET;
    end else if (put_edge) begin
      put_ptr_ff <= nxt_put_ptr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      put_cell_ff <= dclb_pkg::PTR_RESET;
    end else if (put_edge) begin
      put_cell_ff <= put_base;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      put_open_ff <= 1'b0;
    end else if (put_edge) begin
      put_open_ff <= put_go;
    end
  end

  // ***************************************************
  // Fetch side
  // ***************************************************
  logic [ADDR_W-1:0] fetch_ptr_ff;
  logic [WIDTH-1:0]  fetch_data_ff;
  logic              fetch_oe_ff;
  logic [WIDTH-1:0]  store_rd_data;

  wire [ADDR_W-1:0] fetch_base    = fetch_clear ? dclb_pkg::PTR_RESET : fetch_ptr_ff;
  wire [ADDR_W-1:0] fetch_step    = (fetch_base == LAST) ? dclb_pkg::PTR_RESET : fetch_base + ONE;
  wire [ADDR_W-1:0] nxt_fetch_ptr = fetch_go ? fetch_step : fetch_base;

  wire              nxt_fetch_oe   = fetch_go;
  wire [WIDTH-1:0]  nxt_fetch_data = fetch_go ? store_rd_data : fetch_data_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_ptr_ff <= dclb_pkg::PTR_RESET;
    end else if (fetch_edge) begin
      fetch_ptr_ff <= nxt_fetch_ptr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_oe_ff <= 1'b0;
    end else if (fetch_edge) begin
      fetch_oe_ff <= nxt_fetch_oe;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_data_ff <= '0;
    end else if (fetch_edge) begin
      fetch_data_ff <= nxt_fetch_data;
    end
  end

  // ***************************************************
  // Store
  // ***************************************************
  // A read at the mclk edge that writes the same cell returns the old byte;
  // the write-to-read gap that readers keep makes that case unreachable.
  // FIFO line store
  dclb_store #(
    .DEPTH  (DEPTH),
    .WIDTH  (WIDTH),
    .ADDR_W (ADDR_W)
  ) u_store (
    .mclk    (mclk),
    .wr_en   (store_wr_en),
    .wr_addr (put_cell_ff),
    .wr_data (put_byte),
    .rd_addr (fetch_base),
    .rd_data (store_rd_data)
  );

  assign fetch_data    = fetch_data_ff;
  assign fetch_data_oe = fetch_oe_ff;
endmodule

// ### testbench/dclb_checker.sv
/* Fetch side checks for dclb_top.
   Assumes pin clocks are held steady for at least 4 mclk. */
`timescale 1ns/1ps
module dclb_checker (
  // System
  input wire logic       mclk,
  input wire logic       rst,
  // Pins watched
  input wire logic       put_side_clock,
  input wire logic       fetch_side_clock,
  input wire logic       fetch_gate_n,
  input wire logic [7:0] fetch_data,
  input wire logic       fetch_data_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence rd_on; $rose(fetch_side_clock) && !fetch_gate_n; endsequence
  sequence rd_off; $rose(fetch_side_clock) && fetch_gate_n; endsequence
  sequence idle6; (!$rose(fetch_side_clock)) [*6]; endsequence
  read_on_a: assert property (rd_on |-> ##[2:4] fetch_data_oe)
    else $error("gated read left output floating");
  read_off_a: assert property (rd_off |-> ##[2:4] !fetch_data_oe)
    else $error("skipped read still drives");
  skip_hold_a: assert property (rd_off |-> ##5 fetch_data == $past(fetch_data, 5))
    else $error("skipped read changed data");
  idle_stable_a: assert property (idle6 |-> $stable(fetch_data_oe))
    else $error("enable moved without fetch edge");
  data_gated_a: assert property ($changed(fetch_data) |-> fetch_data_oe)
    else $error("data moved while floating");
  oe_cause_a: assert property ($changed(fetch_data_oe) |-> $past(fetch_side_clock))
    else $error("enable moved off a fetch cycle");
  put_indep_a: assert property ($rose(put_side_clock) ##1 idle6 |-> $stable(fetch_data))
    else $error("put edge disturbed fetch data");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !fetch_data_oe)
    else $error("output driven in reset");
endmodule
bind dclb_top dclb_checker i_dclb_checker (.mclk(mclk), .rst(rst),
  .put_side_clock(put_side_clock), .fetch_side_clock(fetch_side_clock),
  .fetch_gate_n(fetch_gate_n), .fetch_data(fetch_data), .fetch_data_oe(fetch_data_oe));

// ### testbench/dclb_line_host.sv
/* Line host model driving both pin sides.
   Assumes the bench calls its tasks one at a time per side. */
`timescale 1ns/1ps
module dclb_line_host (
  // Clock
  input wire logic   mclk,
  // Put side
  output logic       put_side_clock,
  output logic       put_gate_n,
  output logic       put_pointer_clear_n,
  output logic [7:0] put_data,
  // Fetch side
  output logic       fetch_side_clock,
  output logic       fetch_gate_n,
  output logic       fetch_pointer_clear_n
);
  initial begin
    {put_side_clock, put_gate_n, put_pointer_clear_n} = 3'h3;
    {fetch_side_clock, fetch_gate_n, fetch_pointer_clear_n} = 3'h3;
    put_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // a 320 ns pin cycle is slower than either grade, so only the gap binds
  // controls settle 4 mclk early; 8 mclk cycles keep reads behind
  task automatic put_edge(input logic g, input logic c, input logic [7:0] d);
    put_side_clock = 1'b0;
    {put_gate_n, put_pointer_clear_n, put_data} = {g, c, d};
    tick(4);
    put_side_clock = 1'b1;
    tick(4);
  endtask
  // pin clock rests high between calls so no stray rise appears
  task automatic fetch_edge(input logic g, input logic c);
    fetch_side_clock = 1'b0;
    {fetch_gate_n, fetch_pointer_clear_n} = {g, c};
    tick(4);
    fetch_side_clock = 1'b1;
    tick(4);
  endtask
endmodule

// ### testbench/dual_clock_line_buffer_tb.sv
/* Self-checking bench for dclb_top.
   Assumes the host model owns every pin input. */
`timescale 1ns/1ps
module dual_clock_line_buffer_tb;
  logic       mclk;
  logic       rst;
  logic       pck, pg, pc, fck, fg, fc, oe;
  logic [7:0] pd, fd;
  int         failures;
  int         check_count;
  always #20 mclk = ~mclk;
  dclb_line_host i_dclb_line_host (.mclk(mclk), .put_side_clock(pck), .put_gate_n(pg),
    .put_pointer_clear_n(pc), .put_data(pd), .fetch_side_clock(fck),
    .fetch_gate_n(fg), .fetch_pointer_clear_n(fc));
  dclb_top i_dclb_top (.mclk(mclk), .rst(rst), .put_side_clock(pck), .put_gate_n(pg),
    .put_pointer_clear_n(pc), .put_data(pd), .fetch_side_clock(fck), .fetch_gate_n(fg),
    .fetch_pointer_clear_n(fc), .fetch_data(fd), .fetch_data_oe(oe));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: fetch saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] pat(input int i);
    return i[7:0] ^ 8'h5A;
  endfunction
  // ***************************************************
  // Scenarios
  // ***************************************************
  // full line plus two, so cells 0 and 1 are overwritten
  task automatic t_wrap;
    int n;
    int a;
    n = dclb_pkg::DEPTH + 2;
    i_dclb_line_host.put_edge(1'b0, 1'b0, 8'h00);
    for (int i = 0; i < n; i++) i_dclb_line_host.put_edge(i == n - 1, 1'b1, pat(i));
    for (int j = 0; j < n + 2; j++) begin
      a = j % dclb_pkg::DEPTH;
      i_dclb_line_host.fetch_edge(1'b0, j != 0);
      check({oe, fd}, {1'b1, pat(a < 2 ? a + dclb_pkg::DEPTH : a)});
    end
  endtask
  // clear with gate off, then a skipped cycle between two bytes
  task automatic t_gates;
    i_dclb_line_host.put_edge(1'b1, 1'b0, 8'h00);
    i_dclb_line_host.put_edge(1'b0, 1'b1, 8'h00);
    i_dclb_line_host.put_edge(1'b1, 1'b1, 8'hAA);
    i_dclb_line_host.put_edge(1'b0, 1'b1, 8'h00);
    i_dclb_line_host.put_edge(1'b1, 1'b1, 8'hBB);
    i_dclb_line_host.fetch_edge(1'b1, 1'b0);
    check({oe, fd}, {1'b0, pat(3)});
    i_dclb_line_host.fetch_edge(1'b0, 1'b1);
    check({oe, fd}, {1'b1, 8'hAA});
    i_dclb_line_host.fetch_edge(1'b1, 1'b1);
    check({oe, fd}, {1'b0, 8'hAA});
    i_dclb_line_host.fetch_edge(1'b0, 1'b1);
    check({oe, fd}, {1'b1, 8'hBB});
  endtask
  // Mid-run reset floats the output, then both pointers restart at 0
  task automatic t_reset;
    i_dclb_line_host.fetch_edge(1'b0, 1'b1);
    check({oe, fd}, {1'b1, pat(2)});
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    check({oe, fd}, 9'h000);
    i_dclb_line_host.put_edge(1'b0, 1'b1, 8'h00);
    i_dclb_line_host.put_edge(1'b1, 1'b1, 8'hC3);
    i_dclb_line_host.fetch_edge(1'b1, 1'b1);
    check({oe, fd}, 9'h000);
    i_dclb_line_host.fetch_edge(1'b0, 1'b1);
    check({oe, fd}, {1'b1, 8'hC3});
  endtask
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    t_wrap();
    t_gates();
    t_reset();
    report_and_stop();
  end
  // Two line passes need about 81k mclk
  initial begin
    #3600000;
    failures++;
    report_and_stop();
  end
endmodule
